// ---- hdl/mnsce_exec.sv ----
// Functional notes
// - Literal multiply: accumulator times literal, accumulator kept.
// - Product high byte and low byte registers.
// - File multiply: accumulator times file, both kept.
// - Multiplies never touch status flags.
// - Access bit picks access bank or bank select.
// - Negate file register, update five flags.
// - Pop discards top, older entry becomes top.
// - Push program counter plus two.
// - Relative call pushes return, jumps by 2n.
// - Relative call takes two cycles, second idle.
// - Software reset restores external reset values.
`timescale 1ns/1ns
module mnsce_exec (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire mnsce_pkg::mnsce_instr_t instr,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] file_rdata,
  output mnsce_pkg::mnsce_mem_wr_t file_wr,
  output logic [11:0] file_raddr,
  output logic [7:0] product_high_byte,
  output logic [7:0] product_low_byte,
  output logic [4:0] status_flags,
  output logic [7:0] bank_select_reg,
  output logic [mnsce_pkg::PC_W-1:0] program_counter,
  output logic pc_load,
  output logic [mnsce_pkg::PC_W-1:0] stack_top_entry,
  output logic [mnsce_pkg::SP_W-1:0] stack_ptr,
  output logic busy,
  output logic soft_reset
);

  typedef struct packed {
    mnsce_pkg::mnsce_mem_wr_t wr;
    logic [11:0] raddr;
    logic [7:0] prod_hi;
    logic [7:0] prod_lo;
    logic [4:0] flags;
    logic [7:0] bank_sel;
    logic [mnsce_pkg::PC_W-1:0] pc;
    logic pc_load;
    logic [mnsce_pkg::SP_W-1:0] sp;
    logic busy;
    logic soft_reset;
  } mnsce_state_t;

  mnsce_state_t state;
  mnsce_state_t next_state;
  logic [mnsce_pkg::PC_W-1:0] stack_mem [mnsce_pkg::STACK_DEPTH];
  logic stack_we;
  logic [mnsce_pkg::SP_W-1:0] stack_wptr;
  logic [mnsce_pkg::PC_W-1:0] stack_wdata;
  logic [7:0] neg_result;
  logic [4:0] neg_flags;
  logic [15:0] product;
  logic [mnsce_pkg::PC_W-1:0] ret_addr;
  logic [mnsce_pkg::PC_W-1:0] rel_offset;

  // Operand address for the file forms, resolved from access bit and bank.
  function automatic logic [11:0] file_addr(input logic [15:0] w,
                                            input logic [7:0] bank_sel,
                                            input logic ext_en);
    logic [11:0] a;
    a = {bank_sel[3:0], w[7:0]};
    if (!w[8]) begin
      // Indexed literal offset resolution belongs to the front end.
      if (ext_en && w[7:0] <= mnsce_pkg::ACCESS_LIMIT) begin
        a = {4'h0, w[7:0]};
      end else if (w[7:0] >= mnsce_pkg::ACCESS_SFR_BASE) begin
        a = {mnsce_pkg::ACCESS_SFR_BANK, w[7:0]};
      end else begin
        a = {4'h0, w[7:0]};
      end
    end
    return a;
  endfunction

  mnsce_negate u_negate (
    .operand(file_rdata),
    .result(neg_result),
    .flags(neg_flags)
  );

  // The file operand is read combinationally so both forms finish in one
  // cycle; this costs a longer path through the data memory.
  always_comb begin
    file_raddr = file_addr(instr.word, state.bank_sel, instr.ext_set_en);
  end

  always_comb begin
    next_state = state;
    next_state.wr = '0;
    next_state.pc_load = 1'b0;
    next_state.soft_reset = 1'b0;
    next_state.raddr = file_raddr;
    stack_we = 1'b0;
    stack_wptr = state.sp;
    ret_addr = instr.pc + mnsce_pkg::PC_STEP;
    rel_offset = mnsce_pkg::PC_W'({{10{instr.word[10]}}, instr.word[10:0]});
    stack_wdata = ret_addr;
    product = 16'h0000;
    if (state.busy) begin
      next_state.busy = 1'b0;
    end else if (instr.valid) begin
      if (instr.word[15:8] == mnsce_pkg::OP_MUL_LIT) begin
        product = accumulator * instr.word[7:0];
        next_state.prod_hi = product[15:8];
        next_state.prod_lo = product[7:0];
      end else if (instr.word[15:9] == mnsce_pkg::OP_MUL_FILE) begin
        product = accumulator * file_rdata;
        next_state.prod_hi = product[15:8];
        next_state.prod_lo = product[7:0];
      end else if (instr.word[15:9] == mnsce_pkg::OP_NEG_FILE) begin
        next_state.wr.req = 1'b1;
        next_state.wr.addr = file_raddr;
        next_state.wr.data = neg_result;
        next_state.flags = neg_flags;
      end else if (instr.word == mnsce_pkg::OP_POP) begin
        if (state.sp != mnsce_pkg::SP_RST) begin
          next_state.sp = state.sp - 5'h01;
        end
      end else if (instr.word == mnsce_pkg::OP_PUSH) begin
        stack_we = (state.sp != 5'(mnsce_pkg::STACK_DEPTH));
        next_state.sp = state.sp + 5'(stack_we);
      end else if (instr.word[15:11] == mnsce_pkg::OP_REL_CALL) begin
        stack_we = (state.sp != 5'(mnsce_pkg::STACK_DEPTH));
        next_state.sp = state.sp + 5'(stack_we);
        next_state.pc = ret_addr + (rel_offset << 1);
        next_state.pc_load = 1'b1;
        next_state.busy = 1'b1;
      end else if (instr.word == mnsce_pkg::OP_RESET) begin
        next_state.soft_reset = 1'b1;
        next_state.prod_hi = mnsce_pkg::BYTE_RST;
        next_state.prod_lo = mnsce_pkg::BYTE_RST;
        next_state.flags = mnsce_pkg::FLAGS_RST;
        next_state.bank_sel = mnsce_pkg::BYTE_RST;
        next_state.pc = mnsce_pkg::PC_RST;
        next_state.pc_load = 1'b1;
        next_state.sp = mnsce_pkg::SP_RST;
      end else begin
        // Idle words, second words and unhandled opcodes leave state alone.
        next_state.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Entries above the pointer are stale, so the array needs no reset.
  always_ff @(posedge core_clk) begin
    if (stack_we) begin
      stack_mem[stack_wptr] <= stack_wdata;
    end
  end

  // Top of stack reads zero when the stack is empty.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_top_entry <= mnsce_pkg::PC_RST;
    end else if (stack_we) begin
      stack_top_entry <= stack_wdata;
    end else if (next_state.sp == mnsce_pkg::SP_RST) begin
      stack_top_entry <= mnsce_pkg::PC_RST;
    end else begin
      stack_top_entry <= stack_mem[next_state.sp - 5'h01];
    end
  end

  always_comb begin
    file_wr = state.wr;
    product_high_byte = state.prod_hi;
    product_low_byte = state.prod_lo;
    status_flags = state.flags;
    bank_select_reg = state.bank_sel;
    program_counter = state.pc;
    pc_load = state.pc_load;
    stack_ptr = state.sp;
    busy = state.busy;
    soft_reset = state.soft_reset;
  end

endmodule // mnsce_exec

// ---- hdl/mnsce_negate.sv ----
`timescale 1ns/1ns
module mnsce_negate (
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output logic [4:0] flags
);

  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb begin
    sum = {1'b0, ~operand} + 9'h001;
    low_sum = {1'b0, ~operand[3:0]} + 5'h01;
    result = sum[7:0];
    flags = '0;
    flags[mnsce_pkg::FLAG_C] = sum[8];
    flags[mnsce_pkg::FLAG_DC] = low_sum[4];
    flags[mnsce_pkg::FLAG_Z] = (sum[7:0] == 8'h00);
    flags[mnsce_pkg::FLAG_OV] = (operand == 8'h80);
    flags[mnsce_pkg::FLAG_N] = sum[7];
  end

endmodule // mnsce_negate

// ---- hdl/mnsce_pkg.sv ----
package mnsce_pkg;

  localparam int unsigned PC_W = 21;
  localparam int unsigned STACK_DEPTH = 31;
  localparam int unsigned SP_W = 5;

  // Opcode field values.
  localparam logic [7:0] OP_MUL_LIT = 8'h0d;
  localparam logic [6:0] OP_MUL_FILE = 7'h01;
  localparam logic [6:0] OP_NEG_FILE = 7'h36;
  localparam logic [4:0] OP_REL_CALL = 5'h1b;
  localparam logic [3:0] OP_SECOND_WORD = 4'hf;
  localparam logic [15:0] OP_IDLE = 16'h0000;
  localparam logic [15:0] OP_POP = 16'h0006;
  localparam logic [15:0] OP_PUSH = 16'h0005;
  localparam logic [15:0] OP_RESET = 16'h00ff;

  localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SFR_BASE = 8'h60;
  localparam logic [3:0] ACCESS_SFR_BANK = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // Reset values.
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [SP_W-1:0] SP_RST = 5'h00;

  // Status flag bit positions.
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_DC = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned FLAG_N = 4;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic [PC_W-1:0] pc;
    logic ext_set_en;
  } mnsce_instr_t;

  typedef struct packed {
    logic req;
    logic [11:0] addr;
    logic [7:0] data;
  } mnsce_mem_wr_t;

endpackage

// ---- tb/mnsce_exec_monitor.sv ----
`timescale 1ns/1ns
module mnsce_exec_monitor (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire mnsce_pkg::mnsce_instr_t instr,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] file_rdata,
  input wire mnsce_pkg::mnsce_mem_wr_t file_wr,
  input wire logic [11:0] file_raddr,
  input wire logic [7:0] product_high_byte,
  input wire logic [7:0] product_low_byte,
  input wire logic [4:0] status_flags,
  input wire logic [mnsce_pkg::PC_W-1:0] program_counter,
  input wire logic pc_load,
  input wire logic [mnsce_pkg::PC_W-1:0] stack_top_entry,
  input wire logic [mnsce_pkg::SP_W-1:0] stack_ptr,
  input wire logic busy,
  input wire logic soft_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic tk = instr.valid && !busy;
  wire logic [15:0] w = instr.word;
  wire logic [15:0] prod = {product_high_byte, product_low_byte};
  wire logic mulk = tk && w[15:8] == mnsce_pkg::OP_MUL_LIT;
  wire logic mulf = tk && w[15:9] == mnsce_pkg::OP_MUL_FILE;
  wire logic neg = tk && w[15:9] == mnsce_pkg::OP_NEG_FILE;
  wire logic call = tk && w[15:11] == mnsce_pkg::OP_REL_CALL;
  wire logic [20:0] tgt = instr.pc + 21'h2 + {{9{w[10]}}, w[10:0], 1'b0};
  property p_mulk; mulk |=> prod == $past(accumulator) * $past(w[7:0]);
  endproperty
  a_mulk: assert property (p_mulk) else $error("literal product");
  property p_mulf; mulf |=> prod == $past(accumulator) * $past(file_rdata);
  endproperty
  a_mulf: assert property (p_mulf) else $error("file product");
  property p_flag; mulk || mulf |=> $stable(status_flags) && !file_wr.req;
  endproperty
  a_flag: assert property (p_flag) else $error("multiply flags");
  property p_bank; (mulf || neg) && !w[8] |-> file_raddr ==
    {(w[7:0] < 8'h60) ? 4'h0 : 4'hf, w[7:0]}; endproperty
  a_bank: assert property (p_bank) else $error("access bank");
  property p_neg; neg |=> file_wr.req && file_wr.data == 8'h00 -
    $past(file_rdata) && file_wr.addr == $past(file_raddr); endproperty
  a_neg: assert property (p_neg) else $error("negate write");
  property p_pop; tk && w == mnsce_pkg::OP_POP && stack_ptr != 5'h00 |=>
    stack_ptr == $past(stack_ptr) - 5'h01; endproperty
  a_pop: assert property (p_pop) else $error("pop depth");
  property p_push; tk && w == mnsce_pkg::OP_PUSH && stack_ptr != 5'h1f |=>
    stack_top_entry == $past(instr.pc) + 21'h2; endproperty
  a_push: assert property (p_push) else $error("push entry");
  property p_call; call |=> pc_load && program_counter == $past(tgt);
  endproperty
  a_call: assert property (p_call) else $error("call target");
  property p_busy; call |=> busy ##1 !busy; endproperty
  a_busy: assert property (p_busy) else $error("call length");
  property p_rst; tk && w == mnsce_pkg::OP_RESET |=> soft_reset &&
    stack_ptr == 5'h00 && status_flags == 5'h00; endproperty
  a_rst: assert property (p_rst) else $error("soft reset");
  property p_idle; tk && w == mnsce_pkg::OP_IDLE |=> !pc_load &&
    $stable(stack_ptr) && $stable(status_flags); endproperty
  a_idle: assert property (p_idle) else $error("idle changed state");
  c_mulf: cover property (mulf);
  c_call: cover property (call);
  c_neg: cover property (neg);
endmodule // mnsce_exec_monitor
bind mnsce_exec mnsce_exec_monitor u_mon (.core_clk, .rst_b, .instr,
  .accumulator, .file_rdata, .file_wr, .file_raddr, .product_high_byte,
  .product_low_byte, .status_flags, .program_counter, .pc_load,
  .stack_top_entry, .stack_ptr, .busy, .soft_reset);

// ---- tb/mnsce_mem_model.sv ----
`timescale 1ns/1ns
module mnsce_mem_model (
  input wire logic core_clk,
  input wire logic [11:0] raddr,
  input wire mnsce_pkg::mnsce_mem_wr_t wr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:4095];
  // Reads are combinational, since the core reads in the same cycle.
  assign rdata = mem[raddr];
  always @(posedge core_clk) begin
    if (wr.req) mem[wr.addr] <= wr.data;
  end
endmodule // mnsce_mem_model

// ---- tb/mul_negate_stack_call_exec_test.sv ----
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  mismatches++; $display("mismatch %s exp %h got %h", n, e, a); end end
module mul_negate_stack_call_exec_test;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  mnsce_pkg::mnsce_instr_t instr = '0;
  logic [7:0] acc = 8'h00;
  logic [7:0] rdata, ph, pl, bank;
  mnsce_pkg::mnsce_mem_wr_t wr;
  logic [11:0] raddr;
  logic [4:0] flags, sp;
  logic [20:0] pc, top;
  logic pc_load, busy, srst;
  int mismatches = 0;
  int samples_checked = 0;
  mnsce_exec u_dut (.core_clk(core_clk), .rst_b(rst_b), .instr(instr),
    .accumulator(acc), .file_rdata(rdata), .file_wr(wr), .file_raddr(raddr),
    .product_high_byte(ph), .product_low_byte(pl), .status_flags(flags),
    .bank_select_reg(bank), .program_counter(pc), .pc_load(pc_load),
    .stack_top_entry(top), .stack_ptr(sp), .busy(busy), .soft_reset(srst));
  mnsce_mem_model u_mem (.core_clk(core_clk), .raddr(raddr), .wr(wr),
    .rdata(rdata));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic op(input logic [15:0] wd, input logic [20:0] at,
    input logic [7:0] a);
    @(posedge core_clk);
    instr <= '{1'b1, wd, at, 1'b0};
    acc <= a;
    @(posedge core_clk);
    instr.valid <= 1'b0;
    #1;
  endtask
  task automatic t_neg;
    u_mem.mem[12'h03a] = 8'h3a;
    u_mem.mem[12'hf80] = 8'h80;
    op(16'h6c3a, 21'h0, 8'h00);
    `CHK("neg", {1'b1, 12'h03a, 8'hc6, 5'h10}, {wr, flags})
    op(16'h6c80, 21'h0, 8'h00);
    `CHK("neg", {1'b1, 12'hf80, 8'h80, 5'h1a}, {wr, flags})
    $display("test negate done");
  endtask
  task automatic t_mul;
    op(16'h0dc4, 21'h0, 8'he2);
    `CHK("product", 16'had08, {ph, pl})
    u_mem.mem[12'h010] = 8'hb5;
    op(16'h0310, 21'h2, 8'hc4);
    `CHK("product", {16'h8a94, 5'h1a}, {ph, pl, flags})
    $display("test multiply done");
  endtask
  task automatic t_stack;
    op(mnsce_pkg::OP_PUSH, 21'h124, 8'h00);
    op(mnsce_pkg::OP_PUSH, 21'h200, 8'h00);
    `CHK("push", {5'h02, 21'h202}, {sp, top})
    op(16'h0000, 21'h0, 8'h00);
    op(16'hf123, 21'h0, 8'h00);
    `CHK("idle", {1'b0, 5'h02, 21'h202}, {pc_load, sp, top})
    op(mnsce_pkg::OP_POP, 21'h0, 8'h00);
    `CHK("pop", {5'h01, 21'h126}, {sp, top})
    $display("test stack done");
  endtask
  task automatic t_call;
    op(16'hdc00, 21'h124, 8'h00);
    `CHK("call", {2'b11, 21'h1ff926, 21'h126}, {pc_load, busy, pc, top})
    @(posedge core_clk);
    #1;
    `CHK("call end", 2'b00, {pc_load, busy})
    op(16'hdbff, 21'h124, 8'h00);
    `CHK("call", {21'h000924, 5'h03}, {pc, sp})
    $display("test call done");
  endtask
  task automatic t_reset;
    op(mnsce_pkg::OP_RESET, 21'h0, 8'h00);
    `CHK("reset", {1'b1, 34'h0}, {srst, sp, flags, ph, pl, bank})
    $display("test reset done");
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // The tests need well under a hundred cycles; a hang ends the run.
  initial begin
    repeat (500) @(posedge core_clk);
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    t_neg;
    t_mul;
    t_stack;
    t_call;
    t_reset;
    print_verdict;
  end
endmodule // mul_negate_stack_call_exec_test
